// ===== verilog/resolver_phase_counter.sv
// Gated phase counter for a two-speed resolver angle readout
`timescale 1ns/1ps
`default_nettype none
module resolver_phase_counter (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Counting clock tick (2.048 MHz enable, same domain)
  input wire logic i_fine_tick,
  input wire logic i_coarse_tick,
  // Zero-crossing waveform inputs (asynchronous pins)
  input wire logic i_start_phase_wave,
  input wire logic i_stop_phase_wave,
  input wire logic i_coarse_start_wave,
  input wire logic i_excitation_reference,
  // Channel health
  input wire logic i_fine_ref_ok,
  input wire logic i_coarse_ref_ok,
  input wire logic i_fine_failed,
  // Results
  output logic [phase_counter_pkg::CNT_W-1:0] o_fine_count,
  output logic o_fine_valid,
  output logic [phase_counter_pkg::CNT_W-1:0] o_coarse_count,
  output logic o_coarse_valid,
  output logic [phase_counter_pkg::CNT_W-1:0] o_angle_count,
  output logic o_angle_is_coarse,
  output logic o_overrun
);
  localparam int W = phase_counter_pkg::CNT_W;
  localparam logic [W-1:0] LIMIT = W'(phase_counter_pkg::PERIOD_CYCLES);

  // Three-stage synchronisers; change accepted when stages two and three agree
  logic [2:0] s_fst, s_fsp, s_cst, s_csp;
  logic fst_q, fsp_q, cst_q, csp_q;

  // Warm-up after reset: filtered levels follow the pins until a real level has
  // reached stage three, so a wave already high at reset is not taken for a crossing
  logic [phase_counter_pkg::SYNC_LEN-1:0] warm;
  logic warm_done;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      warm <= '0;
    end else begin
      warm <= {warm[phase_counter_pkg::SYNC_LEN-2:0], 1'b1};
    end
  end
  assign warm_done = warm[phase_counter_pkg::SYNC_LEN-1];

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_fst <= 3'h0;
      s_fsp <= 3'h0;
      s_cst <= 3'h0;
      s_csp <= 3'h0;
    end else begin
      s_fst <= {s_fst[1:0], i_start_phase_wave};
      s_fsp <= {s_fsp[1:0], i_stop_phase_wave};
      s_cst <= {s_cst[1:0], i_coarse_start_wave};
      s_csp <= {s_csp[1:0], i_excitation_reference};
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fst_q <= 1'b0;
      fsp_q <= 1'b0;
      cst_q <= 1'b0;
      csp_q <= 1'b0;
    end else if (!warm_done) begin
      fst_q <= s_fst[1];
      fsp_q <= s_fsp[1];
      cst_q <= s_cst[1];
      csp_q <= s_csp[1];
    end else begin
      if (s_fst[1] == s_fst[2]) fst_q <= s_fst[2];
      if (s_fsp[1] == s_fsp[2]) fsp_q <= s_fsp[2];
      if (s_cst[1] == s_cst[2]) cst_q <= s_cst[2];
      if (s_csp[1] == s_csp[2]) csp_q <= s_csp[2];
    end
  end

  // Positive-going crossing detected on the filtered level
  function automatic logic rise(input logic armed, input logic q, input logic [2:0] s);
    rise = armed && !q && s[1] && s[2];
  endfunction : rise

  logic fine_start, fine_stop, coarse_start, coarse_stop;
  assign fine_start = rise(warm_done, fst_q, s_fst);
  assign fine_stop = rise(warm_done, fsp_q, s_fsp);
  assign coarse_start = rise(warm_done, cst_q, s_cst);
  assign coarse_stop = rise(warm_done, csp_q, s_csp);

  // Fine channel: reading spans 64x the mechanical angle, wraps 64 times per turn
  logic [W-1:0] fine_cnt;
  logic fine_gate;
  logic fine_over;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fine_gate <= 1'b0;
      fine_cnt <= '0;
      fine_over <= 1'b0;
      o_fine_count <= '0;
      o_fine_valid <= 1'b0;
    end else if (!i_fine_ref_ok) begin
      fine_gate <= 1'b0;
      o_fine_valid <= 1'b0;
    end else if (fine_gate && fine_stop) begin
      fine_gate <= 1'b0;
      o_fine_count <= fine_cnt;
      o_fine_valid <= !fine_over;
    end else if (fine_start) begin
      fine_gate <= 1'b1;
      fine_cnt <= '0;
      fine_over <= 1'b0;
    end else if (fine_gate && i_fine_tick) begin
      if (fine_cnt == LIMIT - 1'b1) begin
        fine_over <= 1'b1;
        fine_gate <= 1'b0;
        o_fine_valid <= 1'b0;
      end else begin
        fine_cnt <= fine_cnt + 1'b1;
      end
    end
  end

  // Coarse channel: same gated counting, own reference
  logic [W-1:0] coarse_cnt;
  logic coarse_gate;
  logic coarse_over;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      coarse_gate <= 1'b0;
      coarse_cnt <= '0;
      coarse_over <= 1'b0;
      o_coarse_count <= '0;
      o_coarse_valid <= 1'b0;
    end else if (!i_coarse_ref_ok) begin
      coarse_gate <= 1'b0;
      o_coarse_valid <= 1'b0;
    end else if (coarse_gate && coarse_stop) begin
      coarse_gate <= 1'b0;
      o_coarse_count <= coarse_cnt;
      o_coarse_valid <= !coarse_over;
    end else if (coarse_start) begin
      coarse_gate <= 1'b1;
      coarse_cnt <= '0;
      coarse_over <= 1'b0;
    end else if (coarse_gate && i_coarse_tick) begin
      if (coarse_cnt == LIMIT - 1'b1) begin
        coarse_over <= 1'b1;
        coarse_gate <= 1'b0;
        o_coarse_valid <= 1'b0;
      end else begin
        coarse_cnt <= coarse_cnt + 1'b1;
      end
    end
  end

  // Angle selection: coarse only as fallback for a lost fine channel
  logic fine_lost;
  assign fine_lost = i_fine_failed || !i_fine_ref_ok;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_angle_count <= '0;
      o_angle_is_coarse <= 1'b0;
      o_overrun <= 1'b0;
    end else begin
      o_angle_is_coarse <= fine_lost;
      o_angle_count <= fine_lost ? o_coarse_count : o_fine_count;
      o_overrun <= fine_over || coarse_over;
    end
  end

  // Fine channel gate and counter
  AST_GATE_OPENS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_fine_ref_ok && fine_start && !(fine_gate && fine_stop) |=> fine_gate && fine_cnt == '0)
    else $error("fine gate did not open at start");
  AST_START_PULSE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    fine_start |=> !fine_start)
    else $error("fine start pulse lasted more than one clock");
  AST_GATE_CLOSES: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_fine_ref_ok && fine_gate && fine_stop |=> !fine_gate && o_fine_count == $past(fine_cnt))
    else $error("fine gate did not close at stop");
  AST_CLOSED_HALT: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !fine_gate && !fine_start |=> fine_cnt == $past(fine_cnt))
    else $error("fine counter moved with the gate shut");
  AST_COUNT_ADV: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_fine_ref_ok && fine_gate && i_fine_tick && !fine_stop && !fine_start
      && fine_cnt < LIMIT - 1'b1 |=> fine_cnt == $past(fine_cnt) + 1'b1)
    else $error("fine counter did not advance");
  AST_OVERRUN: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_fine_ref_ok && fine_gate && i_fine_tick && !fine_stop && !fine_start
      && fine_cnt == LIMIT - 1'b1 |=> !fine_gate && fine_over && !o_fine_valid)
    else $error("fine window ran past one excitation period");
  AST_COUNT_BOUND: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    fine_cnt < LIMIT && coarse_cnt < LIMIT)
    else $error("count exceeded one excitation period");
  AST_FINE_WRAP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_fine_valid |-> o_fine_count < LIMIT)
    else $error("fine reading outside one electrical cycle");
  AST_REF_LOSS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_fine_ref_ok |=> !fine_gate && !o_fine_valid)
    else $error("fine channel ran without reference");
  AST_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !(fine_gate && fine_stop) |=> o_fine_count == $past(o_fine_count))
    else $error("held fine result changed");

  // Coarse channel gate and counter
  AST_COARSE_OPENS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_coarse_ref_ok && coarse_start && !(coarse_gate && coarse_stop)
      |=> coarse_gate && coarse_cnt == '0)
    else $error("coarse gate did not open at start");
  AST_COARSE_CLOSE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_coarse_ref_ok && coarse_gate && coarse_stop |=> !coarse_gate)
    else $error("coarse gate did not close");
  AST_COARSE_ADV: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_coarse_ref_ok && coarse_gate && i_coarse_tick && !coarse_stop && !coarse_start
      && coarse_cnt < LIMIT - 1'b1 |=> coarse_cnt == $past(coarse_cnt) + 1'b1)
    else $error("coarse counter did not advance");
  AST_COARSE_LOSS: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_coarse_ref_ok |=> !coarse_gate && !o_coarse_valid)
    else $error("coarse channel ran without reference");
  AST_COARSE_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !(coarse_gate && coarse_stop) |=> o_coarse_count == $past(o_coarse_count))
    else $error("held coarse result changed");

  // Angle source selection
  AST_FALLBACK: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !fine_lost ##1 !fine_lost |-> !o_angle_is_coarse && o_angle_count == $past(o_fine_count))
    else $error("coarse used while fine healthy");
  AST_ANGLE_COARSE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    fine_lost |=> o_angle_is_coarse && o_angle_count == $past(o_coarse_count))
    else $error("fine channel lost but angle not from coarse");
endmodule : resolver_phase_counter
`default_nettype wire

// ===== verilog/phase_counter_pkg.sv
// Constants and carrier types for the resolver phase counter
// How it works
// - Start crossing opens gate; count each clock
// - Stop crossing closes gate, halts counting
// - Fine phase offset is 64 times angle
// - Fine count ambiguous; resolve with coarse count (here coarse only replaces a lost fine count)
// - Coarse start from network, stop from excitation
// - Coarse angle used only when fine failed (here also whenever i_fine_ref_ok is low)
// - Each channel has its own reference enable
// - Window spans at most one excitation period
`default_nettype none
package phase_counter_pkg;
  localparam int CNT_HZ = 2048000;
  localparam int EXC_HZ = 1016;
  // One excitation period of counting clocks, rounded down
  localparam int PERIOD_CYCLES = CNT_HZ / EXC_HZ;
  localparam int CNT_W = 12;
  localparam int FINE_MULT = 64;
  localparam int SYNC_LEN = 3;
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic valid;
    logic overrun;
  } reading_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARMED = 3'b010,
    ST_GATE = 3'b100
  } gate_state_t;
endpackage : phase_counter_pkg
`default_nettype wire

// ===== dv/phase_far_side.sv
// Far-side model: counting ticks and squared zero-crossing waves
`timescale 1ns/1ps
`default_nettype none
module phase_far_side (
  // Clock
  input wire logic i_mclk,
  // Drive to the block
  output logic o_fine_tick,
  output logic o_coarse_tick,
  output logic o_start,
  output logic o_stop,
  output logic o_cstart,
  output logic o_exc
);
  initial {o_fine_tick, o_coarse_tick, o_start, o_stop, o_cstart, o_exc} = 6'h00;
  // Ticks only while the gate is open, so the expected count is exact
  task automatic measure(input bit coarse, input int k, input bit stop);
    @(posedge i_mclk);
    if (coarse) o_cstart <= 1'b1;
    else o_start <= 1'b1;
    repeat (8) @(posedge i_mclk);
    repeat (k) begin
      o_fine_tick <= !coarse;
      o_coarse_tick <= coarse;
      @(posedge i_mclk);
      {o_fine_tick, o_coarse_tick} <= 2'h0;
      @(posedge i_mclk);
    end
    if (stop && coarse) o_exc <= 1'b1;
    else if (stop) o_stop <= 1'b1;
    repeat (8) @(posedge i_mclk);
    {o_start, o_stop, o_cstart, o_exc} <= 4'h0;
    repeat (8) @(posedge i_mclk);
  endtask : measure
endmodule : phase_far_side
`default_nettype wire

// ===== dv/resolver_phase_counter_test.sv
// Self-checking bench for the resolver phase counter
`timescale 1ns/1ps
`default_nettype none
module resolver_phase_counter_test;
  logic clk, rst_b, fine_ok, coarse_ok, fine_failed, ft, ct, sw, pw, cw, ew;
  logic [phase_counter_pkg::CNT_W-1:0] fine_cnt, coarse_cnt, angle_cnt;
  logic fine_v, coarse_v, is_coarse, overrun;
  int errors = 0;
  int checks = 0;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  phase_far_side u_far (.i_mclk(clk), .o_fine_tick(ft), .o_coarse_tick(ct), .o_start(sw),
    .o_stop(pw), .o_cstart(cw), .o_exc(ew));
  resolver_phase_counter u_dut (.i_mclk(clk), .i_rst_b(rst_b), .i_fine_tick(ft),
    .i_coarse_tick(ct), .i_start_phase_wave(sw), .i_stop_phase_wave(pw),
    .i_coarse_start_wave(cw), .i_excitation_reference(ew), .i_fine_ref_ok(fine_ok),
    .i_coarse_ref_ok(coarse_ok), .i_fine_failed(fine_failed), .o_fine_count(fine_cnt),
    .o_fine_valid(fine_v), .o_coarse_count(coarse_cnt), .o_coarse_valid(coarse_v),
    .o_angle_count(angle_cnt), .o_angle_is_coarse(is_coarse), .o_overrun(overrun));
  task automatic chk_cnt(input logic [11:0] got, input int exp, input string m);
    checks++;
    if (got !== exp[11:0]) begin
      errors++;
      $display("unexpected at %0t: %s got %0d", $time, m, got);
    end
  endtask : chk_cnt
  task automatic chk_flag(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b", $time, m, got);
    end
  endtask : chk_flag
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic test_fine;
    u_far.measure(1'b0, 37, 1'b1);
    chk_cnt(fine_cnt, 37, "fine count");
    chk_flag(fine_v, 1'b1, "fine valid");
    chk_cnt(angle_cnt, 37, "angle");
    chk_flag(is_coarse, 1'b0, "angle source");
    $display("test_fine done");
  endtask : test_fine
  task automatic test_coarse;
    fine_failed <= 1'b1;
    u_far.measure(1'b1, 5, 1'b1);
    chk_cnt(coarse_cnt, 5, "coarse count");
    chk_flag(coarse_v, 1'b1, "coarse valid");
    chk_cnt(angle_cnt, 5, "angle");
    chk_flag(is_coarse, 1'b1, "angle source");
    chk_cnt(fine_cnt, 37, "fine held");
    fine_failed <= 1'b0;
    $display("test_coarse done");
  endtask : test_coarse
  task automatic test_overrun;
    // Full period with no stop must abort rather than report a wrapped count
    u_far.measure(1'b0, phase_counter_pkg::PERIOD_CYCLES, 1'b0);
    chk_flag(overrun, 1'b1, "overrun");
    chk_flag(fine_v, 1'b0, "fine valid");
    u_far.measure(1'b0, 0, 1'b1);
    chk_cnt(fine_cnt, 0, "zero count");
    chk_flag(overrun, 1'b0, "overrun cleared");
    $display("test_overrun done");
  endtask : test_overrun
  task automatic test_ref;
    fine_ok <= 1'b0;
    u_far.measure(1'b0, 9, 1'b1);
    chk_flag(fine_v, 1'b0, "fine valid");
    chk_flag(is_coarse, 1'b1, "angle source");
    chk_cnt(angle_cnt, 5, "angle fallback");
    fine_ok <= 1'b1;
    coarse_ok <= 1'b0;
    u_far.measure(1'b1, 3, 1'b1);
    chk_flag(coarse_v, 1'b0, "coarse valid");
    chk_cnt(coarse_cnt, 5, "coarse held");
    chk_flag(is_coarse, 1'b0, "angle source");
    chk_cnt(angle_cnt, 0, "angle fine");
    coarse_ok <= 1'b1;
    $display("test_ref done");
  endtask : test_ref
  initial begin
    rst_b = 1'b0;
    fine_ok = 1'b1;
    coarse_ok = 1'b1;
    fine_failed = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk_flag(fine_v, 1'b0, "reset valid");
    test_fine();
    test_coarse();
    test_overrun();
    test_ref();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule : resolver_phase_counter_test
`default_nettype wire
